/* core/cigc_pkg.sv */
// Operation
// RULE_01: Bit 7 set enables ring indicate on the shared battery/ring pin; default off.
// RULE_02: Bit 6 drives card reset; 0 (default) asserts it, 1 releases it.
// RULE_03: Software card reset acts only when a 16-bit card is in the socket.
// RULE_04: Bit 5 records card kind; 0 memory (default), 1 I/O card.
// RULE_05: Bit 4 counts only while the diagnostic routing bit is 0.
// RULE_06: Effective bit 4 set sends status changes to bus lines, else config-register routing.
// RULE_07: Bits 3:0 pick the I/O card irq line; 0000 none, ORed into bus routing.
// RULE_08: Codes 0001 line 1, 0010 system management irq, 0011 line 3, 0100 line 4.
// RULE_09: Other nonzero codes route to the legacy line numbered as the code.
// RULE_10: Reset and kind bits clear on global reset only while power events enabled; code clears them on any global reset, or bus reset with PME off.
// RULE_11: Two sockets each own a copy: offsets 03h, 43h, and 803h above base.
package cigc_pkg;
  localparam logic [11:0] CIGC_OFS_A     = 12'h003;
  localparam logic [11:0] CIGC_OFS_B     = 12'h043;
  localparam logic [11:0] CIGC_OFS_MMIO  = 12'h803;
  localparam int          CIGC_BIT_RING  = 7;
  localparam int          CIGC_BIT_RST   = 6;
  localparam int          CIGC_BIT_KIND  = 5;
  localparam int          CIGC_BIT_ROUTE = 4;
  localparam logic [7:0]  CIGC_RESET_VAL = 8'h00;
  localparam logic [3:0]  CIGC_SEL_NONE  = 4'h0;
  localparam logic [3:0]  CIGC_SEL_SMI   = 4'h2;
  localparam int          CIGC_NSOCK     = 2;
endpackage

/* core/cigc_regs.sv */
`timescale 1ns/1ps
module cigc_regs
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        global_reset,
  input  wire logic        host_bus_reset,
  input  wire logic        pme_enable,
  input  wire logic        diag_csc_route,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_mmio,
  input  wire logic        reg_sock,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic [1:0]  card_is_16bit,
  input  wire logic [1:0]  card_irq_req,
  input  wire logic [1:0]  card_status_change,
  input  wire logic [1:0]  battery_detect_ring_pin,
  output logic      [7:0]  reg_rdata,
  output logic      [1:0]  card_reset_out,
  output logic      [1:0]  ring_indicate,
  output logic      [1:0]  csc_to_bus,
  output logic      [1:0]  csc_to_cfg,
  output logic      [1:0]  smi_out,
  output logic      [15:0] legacy_irq
);
  import cigc_pkg::*;

  logic [7:0]  ctl_q [CIGC_NSOCK];
  logic [1:0]  hit;
  logic [7:0]  rdata_d;
  logic [1:0]  card_reset_d, ring_d, bus_d, cfg_d, smi_d;
  logic [15:0] irq_d;

  // Socket decode: local offsets, or MMIO base + 803h with socket chosen by reg_sock
  function automatic logic sock_hit(input logic [11:0] a, input logic m, input logic s,
                                    input int idx);
    if (m)
      sock_hit = (a == CIGC_OFS_MMIO) && (s == idx[0]); // RULE_11
    else if (idx == 0)
      sock_hit = (a == CIGC_OFS_A);                       // RULE_11
    else
      sock_hit = (a == CIGC_OFS_B);                       // RULE_11
  endfunction

  // One register copy per socket
  genvar g;
  generate
    for (g = 0; g < CIGC_NSOCK; g++)
    begin : g_sock
      logic ctx_clr;
      assign hit[g]  = sock_hit(reg_addr, reg_mmio, reg_sock, g);
      // Power-event context bits survive the bus reset while PME is on
      assign ctx_clr = global_reset || (host_bus_reset && !pme_enable); // RULE_10

      always_ff @(posedge ref_clk or posedge reset)
      begin
        if (reset)
          ctl_q[g] <= CIGC_RESET_VAL;
        else if (clk_en)
        begin
          if (reg_wr && hit[g])
            ctl_q[g] <= reg_wdata;
          // Resets follow the write so they win a same-cycle clash
          if (global_reset || host_bus_reset)
          begin
            ctl_q[g][CIGC_BIT_RING]  <= 1'b0;
            ctl_q[g][CIGC_BIT_ROUTE] <= 1'b0;
            ctl_q[g][3:0]            <= CIGC_SEL_NONE;
          end
          if (ctx_clr)
          begin
            ctl_q[g][CIGC_BIT_RST]  <= 1'b0; // RULE_10
            ctl_q[g][CIGC_BIT_KIND] <= 1'b0; // RULE_10
          end
        end
      end

      always_comb
      begin
        logic route_eff;
        logic [3:0] sel;
        route_eff = 1'b0;
        sel       = ctl_q[g][3:0];
        route_eff = !diag_csc_route && ctl_q[g][CIGC_BIT_ROUTE];          // RULE_05
        // Reset asserted (low release bit) only gates 16-bit cards
        card_reset_d[g] = card_is_16bit[g] && !ctl_q[g][CIGC_BIT_RST];  // RULE_02 RULE_03
        ring_d[g] = ctl_q[g][CIGC_BIT_RING] && battery_detect_ring_pin[g]; // RULE_01
        bus_d[g]  = card_status_change[g] && (route_eff || sel == CIGC_SEL_NONE); // RULE_06 RULE_07
        cfg_d[g]  = card_status_change[g] && !(route_eff || sel == CIGC_SEL_NONE); // RULE_06
        // Functional irq only meaningful for I/O cards
        smi_d[g]  = card_irq_req[g] && ctl_q[g][CIGC_BIT_KIND] && sel == CIGC_SEL_SMI; // RULE_08 RULE_04
      end
    end
  endgenerate

  // Sockets share the legacy lines; select code is the line index
  always_comb
  begin
    irq_d = 16'h0000;
    for (int s = 0; s < CIGC_NSOCK; s++)
      if (card_irq_req[s] && ctl_q[s][CIGC_BIT_KIND] && ctl_q[s][3:0] != CIGC_SEL_NONE
          && ctl_q[s][3:0] != CIGC_SEL_SMI)
        irq_d[ctl_q[s][3:0]] = 1'b1; // RULE_08 RULE_09
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    if (hit[0])
      rdata_d = ctl_q[0];
    else if (hit[1])
      rdata_d = ctl_q[1];
    else
      rdata_d = 8'h00;
  end

  // Read data holds between reads so a slow host can sample late
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (clk_en && reg_rd)
      reg_rdata <= rdata_d;
  end

  // Outputs registered; card reset powers up asserted
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      card_reset_out <= 2'b11;
      ring_indicate  <= 2'b00;
      csc_to_bus     <= 2'b00;
      csc_to_cfg     <= 2'b00;
      smi_out        <= 2'b00;
      legacy_irq     <= 16'h0000;
    end
    else if (clk_en)
    begin
      card_reset_out <= card_reset_d; // RULE_02
      ring_indicate  <= ring_d;
      csc_to_bus     <= bus_d;
      csc_to_cfg     <= cfg_d;
      smi_out        <= smi_d;
      legacy_irq     <= irq_d;
    end
  end

  // Outputs are registered, so each check looks one enabled cycle after its cause; a_release_lag looks two
  a_rst_follows_bit: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
    clk_en |=> card_reset_out[0] ==
      ($past(card_is_16bit[0]) && !$past(ctl_q[0][CIGC_BIT_RST])))
    else $error("card reset mismatch");
  a_rst_only_16: assert property (@(posedge ref_clk) disable iff (reset) // RULE_03
    (clk_en && !card_is_16bit[1]) |=> !card_reset_out[1])
    else $error("reset on non 16-bit card");

  sequence s_release_write;
    clk_en && reg_wr && hit[0] && reg_wdata[CIGC_BIT_RST]
      && !global_reset && !host_bus_reset ##1 clk_en;
  endsequence
  // Release lands two edges after the write: register, then pin flop
  a_release_lag: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
    s_release_write |=> !card_reset_out[0])
    else $error("card reset not released after write");
  a_ring_gate: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
    (clk_en && !ctl_q[0][CIGC_BIT_RING]) |=> !ring_indicate[0])
    else $error("ring while disabled");
  a_ring_pass: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
    (clk_en && ctl_q[0][CIGC_BIT_RING] && battery_detect_ring_pin[0]) |=> ring_indicate[0])
    else $error("ring not passed while enabled");

  // Diagnostic control overrides the per-socket route bit
  a_diag_ignores: assert property (@(posedge ref_clk) disable iff (reset) // RULE_05
    (clk_en && diag_csc_route && ctl_q[0][3:0] != 4'h0 && card_status_change[0])
      |=> csc_to_cfg[0])
    else $error("route bit not ignored");
  a_route_bus: assert property (@(posedge ref_clk) disable iff (reset) // RULE_06
    (clk_en && !diag_csc_route && ctl_q[0][CIGC_BIT_ROUTE] && card_status_change[0])
      |=> csc_to_bus[0] && !csc_to_cfg[0])
    else $error("status change not on bus");
  a_none_or: assert property (@(posedge ref_clk) disable iff (reset) // RULE_07
    (clk_en && ctl_q[1][3:0] == 4'h0 && card_status_change[1]) |=> csc_to_bus[1])
    else $error("zero select not ORed");
  a_zero_no_irq: assert property (@(posedge ref_clk) disable iff (reset) // RULE_07
    (clk_en && card_irq_req[0] && ctl_q[0][3:0] == CIGC_SEL_NONE && !card_irq_req[1])
      |=> !smi_out[0] && legacy_irq == 16'h0000)
    else $error("zero select raised a line");
  a_smi_code: assert property (@(posedge ref_clk) disable iff (reset) // RULE_08
    (clk_en && card_irq_req[0] && ctl_q[0][CIGC_BIT_KIND] && ctl_q[0][3:0] == 4'h2
      && !card_irq_req[1]) |=> smi_out[0] && legacy_irq == 16'h0000)
    else $error("smi code misrouted");
  a_line_code: assert property (@(posedge ref_clk) disable iff (reset) // RULE_09
    (clk_en && card_irq_req[0] && ctl_q[0][CIGC_BIT_KIND] && ctl_q[0][3:0] == 4'h9)
      |=> legacy_irq[9])
    else $error("legacy line misrouted");

  // Context bits ride through a bus reset only while power events are on
  a_ctx_keep: assert property (@(posedge ref_clk) disable iff (reset) // RULE_10
    (clk_en && host_bus_reset && pme_enable && !global_reset && !reg_wr)
      |=> ctl_q[0][CIGC_BIT_KIND] == $past(ctl_q[0][CIGC_BIT_KIND]))
    else $error("kind bit lost on bus reset");
  a_global_clears: assert property (@(posedge ref_clk) disable iff (reset) // RULE_10
    (clk_en && global_reset) |=> !ctl_q[0][CIGC_BIT_RST] && !ctl_q[0][CIGC_BIT_KIND])
    else $error("global reset left context bits");
  a_kind_write: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04 RULE_11
    (clk_en && reg_wr && hit[1] && !global_reset && !host_bus_reset)
      |=> ctl_q[1][CIGC_BIT_KIND] == $past(reg_wdata[5]))
    else $error("kind bit not written");

  // Window access reaches socket B's copy through the shared offset
  sequence s_mmio_write_b;
    clk_en && reg_wr && reg_mmio && reg_sock && reg_addr == CIGC_OFS_MMIO
      && !global_reset && !host_bus_reset;
  endsequence
  a_mmio_write: assert property (@(posedge ref_clk) disable iff (reset) // RULE_11
    s_mmio_write_b |=> ctl_q[1] == $past(reg_wdata))
    else $error("window write missed socket B");
endmodule

/* testbench/cigc_card_model.sv */
`timescale 1ns/1ps
module cigc_card_model
(
  input  wire logic       ref_clk,
  input  wire logic [1:0] k16,
  input  wire logic [1:0] kirq,
  input  wire logic [1:0] kevt,
  input  wire logic [1:0] kring,
  output logic      [1:0] card_is_16bit,
  output logic      [1:0] card_irq_req,
  output logic      [1:0] card_status_change,
  output logic      [1:0] battery_detect_ring_pin
);
  // Card pins move only after an edge, one cycle behind the request
  always_ff @(posedge ref_clk)
  begin
    card_is_16bit           <= k16;
    card_irq_req            <= kirq;
    card_status_change      <= kevt;
    battery_detect_ring_pin <= kring;
  end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  import cigc_pkg::*;
  logic        ref_clk = 0, reset = 1, clk_en = 1, global_reset = 0, host_bus_reset = 0;
  logic        pme_enable = 0, diag_csc_route = 1, reg_wr = 0, reg_rd = 0, reg_mmio = 0;
  logic        reg_sock = 0, rd_q = 0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00, v, reg_rdata;
  logic [1:0]  k16 = 2'h3, kirq = 2'h0, kevt = 2'h0, kring = 2'h0;
  logic [1:0]  card_is_16bit, card_irq_req, card_status_change, battery_detect_ring_pin;
  logic [1:0]  card_reset_out, ring_indicate, csc_to_bus, csc_to_cfg, smi_out;
  logic [15:0] legacy_irq;
  logic [7:0]  expq[$];
  logic [8:0]  cs[4] = '{9'h011, 9'h001, 9'h111, 9'h110};
  int          bad_count = 0, n_tests = 0, seed = 32'h463d76db;
  cigc_regs cigc_regs_inst (.*);
  cigc_card_model cigc_card_model_inst (.*);
  always #12.5 ref_clk = ~ref_clk;
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Address word is {mmio, socket, offset}; on a read the data is the expectation
  task acc(input logic w, input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= !w;
    {reg_mmio, reg_sock, reg_addr} <= a;
    reg_wdata <= d;
    if (!w)
      expq.push_back(d);
    @(posedge ref_clk);
    reg_wr <= 0;
    reg_rd <= 0;
  endtask
  task settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task pulse(input logic g);
    @(posedge ref_clk);
    host_bus_reset <= !g;
    global_reset <= g;
    @(posedge ref_clk);
    host_bus_reset <= 0;
    global_reset <= 0;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
    rd_q <= reg_rd;
  always @(negedge ref_clk)
    if (rd_q)
      chk(reg_rdata, expq.pop_front());
  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 0;
    acc(0, 14'h0003, CIGC_RESET_VAL);
    acc(0, 14'h0043, CIGC_RESET_VAL);
    settle;
    chk(card_reset_out, 2'h3);
    v = 8'($random(seed));
    acc(1, 14'h0003, v);
    acc(1, 14'h3803, ~v);
    acc(1, 14'h0007, 8'h5a);
    clk_en <= 0;
    acc(1, 14'h2803, 8'h5a);
    clk_en <= 1;
    acc(0, 14'h2803, v);
    acc(0, 14'h3803, ~v);
    acc(0, 14'h0013, 8'h00);
    $display("register map done");
    acc(1, 14'h0043, 8'h00);
    acc(1, 14'h0003, 8'h40);
    settle;
    chk(card_reset_out, 2'h2);
    @(posedge ref_clk);
    k16 <= 2'h0;
    acc(1, 14'h0003, 8'h00);
    settle;
    chk(card_reset_out, 2'h0);
    @(posedge ref_clk);
    k16 <= 2'h3;
    kring <= 2'h3;
    acc(1, 14'h0003, 8'h80);
    settle;
    chk(ring_indicate, 2'h1);
    $display("reset and ring done");
    @(posedge ref_clk);
    kring <= 2'h0;
    kevt <= 2'h3;
    for (int j = 0; j < 4; j++)
    begin
      @(posedge ref_clk);
      diag_csc_route <= cs[j][8];
      acc(1, 14'h0003, cs[j][7:0]);
      settle;
      chk({csc_to_bus[0], csc_to_cfg[0]}, (j == 0 || j == 3) ? 2'h2 : 2'h1);
    end
    @(posedge ref_clk);
    kevt <= 2'h0;
    kirq <= 2'h1;
    for (int i = 1; i < 16; i++)
    begin
      acc(1, 14'h0003, {4'h2, i[3:0]});
      settle;
      chk(smi_out, (i == 2) ? 2'h1 : 2'h0);
      chk(legacy_irq, (i == 2) ? 16'h0000 : 16'h0001 << i);
    end
    acc(1, 14'h0003, 8'h03);
    settle;
    chk(legacy_irq, 16'h0000);
    $display("routing done");
    @(posedge ref_clk);
    pme_enable <= 1;
    acc(1, 14'h0003, 8'hff);
    pulse(0);
    acc(0, 14'h0003, 8'h60);
    pulse(1);
    acc(0, 14'h0003, 8'h00);
    pme_enable <= 0;
    acc(1, 14'h0003, 8'hff);
    pulse(0);
    acc(0, 14'h0003, 8'h00);
    repeat (3) @(posedge ref_clk);
    $display("reset domains done");
    conclude;
  end
  initial
  begin
    #100000;
    bad_count++;
    conclude;
  end
endmodule
